// ==== rtl/dsr_pkg.sv ====
// Package for the dual DAC serial front end and reset logic.
// Assumes a 40 MHz system clock that oversamples the serial link pins.
package dsr_pkg;
  localparam int          FRAME_BITS    = 24;
  localparam int          DATA_BITS     = 16;
  localparam int          CNT_W         = 5;
  localparam logic [4:0]  FRAME_LAST    = 5'h17;
  localparam logic [23:0] SHIFT_RST     = 24'h000000;
  localparam logic [15:0] CODE_ZERO     = 16'h0000;
  localparam logic [15:0] CODE_MID      = 16'h8000;
  localparam int          CLK_MHZ       = 40;
  localparam int          SCLK_MAX_MHZ  = 50;
  // Nanoseconds the reset select level must stay stable before init completes.
  localparam int          INIT_NS       = 100;
  localparam int          INIT_CYCLES   = (INIT_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    DSR_ST_HOLD = 2'b00,
    DSR_ST_INIT = 2'b01,
    DSR_ST_RUN  = 2'b10
  } dsr_state_t;
endpackage

// ==== rtl/dsr_link_if.sv ====
// Interface carrying synchronised link levels from the pin synchroniser to the core.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface dsr_link_if;
  logic        sclk_fall;
  logic        sclk_rise;
  logic        frame_n;
  logic        data;
  modport sync_side (output sclk_fall, output sclk_rise, output frame_n, output data);
  modport core_side (input sclk_fall, input sclk_rise, input frame_n, input data);
endinterface

// ==== rtl/dsr_pin_sync.sv ====
// Pin synchroniser and serial clock edge finder.
// Assumes pins are asynchronous to clock and the link clock is slower than clock/2.
`timescale 1ns/1ps
module dsr_pin_sync (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic sclk_pin,
  input  wire logic frame_n_pin,
  input  wire logic serial_in_pin,
  dsr_link_if.sync_side lnk
);
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic       sclk_prev_ff;

  // Two flops per pin; only the second stage feeds logic.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_ff      <= 3'h7;
      sync_ff      <= 3'h7;
      sclk_prev_ff <= 1'b1;
    end
    else
    begin
      meta_ff      <= {sclk_pin, frame_n_pin, serial_in_pin};
      sync_ff      <= meta_ff;
      sclk_prev_ff <= sync_ff[2];
    end
  end

  // Edge pulses are single cycles of clock.
  assign lnk.sclk_fall = sclk_prev_ff & ~sync_ff[2];
  assign lnk.sclk_rise = ~sclk_prev_ff & sync_ff[2];
  assign lnk.frame_n   = sync_ff[1];
  assign lnk.data      = sync_ff[0];
endmodule

// ==== rtl/dsr_core.sv ====
// Serial input front end and reset logic of a dual voltage output DAC.
// Assumes a host master on the link pins and a 40 MHz clock that oversamples them.
// What this block does
// RULE_01 - After frame select falls, capture data on the next 24 falling clock edges.
// RULE_02 - A 24-bit input shift register samples serial data on falling clock edges.
// RULE_03 - Link clock up to 50 MHz accepted; host must not exceed it. The 40 MHz oversampling here resolves only link clocks well below that.
// RULE_04 - Reset input is asynchronous and acts on its falling edge.
// RULE_05 - While reset is low, every load pulse is ignored.
// RULE_06 - Reset loads input and DAC registers with zero scale or midscale.
// RULE_07 - Reset held low at power-up defers initialisation until release.
// RULE_08 - Power-up level is zero scale for select low, midscale for select high.
// RULE_09 - Out of reset the internal reference drives the reference pin as output.
// RULE_10 - A low load pulse copies input registers to DAC registers together.
// RULE_11 - Serial output shifts on rising clock edges for falling-edge sampling.
// RULE_12 - Zero scale is all zeros; midscale has only the top data bit set.
`timescale 1ns/1ps
module dsr_core
  import dsr_pkg::*;
#(
  parameter int DW = dsr_pkg::DATA_BITS
)(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             sclk,
  input  wire logic             frame_n,
  input  wire logic             serial_in,
  input  wire logic             reset_n,
  input  wire logic             load_outputs_n,
  input  wire logic             reset_level_select,
  input  wire logic             ext_ref_select,
  output logic                  serial_out,
  output logic [DW-1:0]         dac_a_ff,
  output logic [DW-1:0]         dac_b_ff,
  output logic [DW-1:0]         input_a_ff,
  output logic [DW-1:0]         input_b_ff,
  output logic [23:0]           frame_word_ff,
  output logic                  frame_done_ff,
  output logic                  ref_out_en_ff,
  output logic                  ready_ff
);
  import dsr_pkg::*;

  dsr_link_if lnk ();

  // Two-flop sampling at 40 MHz resolves link clocks only up to about a third of clock.
  // RULE_03 link clock sampling
  dsr_pin_sync u_sync (
    .clock         (clock),
    .rst           (rst),
    .sclk_pin      (sclk),
    .frame_n_pin   (frame_n),
    .serial_in_pin (serial_in),
    .lnk           (lnk.sync_side)
  );

  logic [2:0]       ctl_meta_ff;
  logic [2:0]       ctl_ff;
  logic             rstn_prev_ff;
  logic             load_outputs_n_prev_ff;
  dsr_state_t       state_ff;
  dsr_state_t       nxt_state;
  logic [7:0]       init_cnt_ff;
  logic [23:0]      shift_ff;
  logic [CNT_W-1:0] bit_cnt_ff;
  logic             in_frame_ff;
  logic             sdo_ff;

  // Zero scale or midscale from the select level.
  function automatic logic [DW-1:0] reset_code(input logic mid);
    reset_code = mid ? DW'(CODE_MID >> (DATA_BITS - DW)) : DW'(CODE_ZERO);
  endfunction

  // Control pins pass two flops; the first stage is read by nothing else.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctl_meta_ff <= 3'h3;
      ctl_ff      <= 3'h3;
    end
    else
    begin
      ctl_meta_ff <= {reset_level_select, reset_n, load_outputs_n};
      ctl_ff      <= ctl_meta_ff;
    end
  end

  wire sel_mid   = ctl_ff[2];
  wire rstn_lvl  = ctl_ff[1];
  wire load_outputs_n_lvl  = ctl_ff[0];
  // Falling edge of the reset input starts the reset action.
  // RULE_04 reset falling edge
  wire rst_fall  = rstn_prev_ff & ~rstn_lvl;
  // A load pulse counts on its falling edge, only while reset is released.
  wire load_outputs_n_fall = load_outputs_n_prev_ff & ~load_outputs_n_lvl & rstn_lvl & (state_ff == DSR_ST_RUN);
  wire capture   = in_frame_ff & lnk.sclk_fall;
  wire last_bit  = capture & (bit_cnt_ff == FRAME_LAST);
  wire frame_go  = ~lnk.frame_n & ~in_frame_ff & ~frame_done_ff;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rstn_prev_ff <= 1'b1;
      load_outputs_n_prev_ff <= 1'b1;
    end
    else
    begin
      rstn_prev_ff <= rstn_lvl;
      load_outputs_n_prev_ff <= load_outputs_n_lvl;
    end
  end

  // Power-up waits in HOLD while reset is low, then settles the select level.
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      DSR_ST_HOLD: if (rstn_lvl) nxt_state = DSR_ST_INIT;
      DSR_ST_INIT: if (!rstn_lvl) nxt_state = DSR_ST_HOLD;
                   else if (init_cnt_ff == 8'(INIT_CYCLES)) nxt_state = DSR_ST_RUN;
      DSR_ST_RUN:  if (rst_fall) nxt_state = DSR_ST_HOLD;
      default:     nxt_state = DSR_ST_HOLD;
    endcase
  end

  // RULE_07 power-up deferral
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_ff    <= DSR_ST_HOLD;
      init_cnt_ff <= 8'h00;
      ready_ff    <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      init_cnt_ff <= (state_ff == DSR_ST_INIT) ? init_cnt_ff + 8'h01 : 8'h00;
      ready_ff    <= (nxt_state == DSR_ST_RUN);
    end
  end

  // RULE_01 frame framing
  // RULE_02 shift register capture
  // The oversampled link tolerates clocks well below the documented maximum only.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      shift_ff      <= SHIFT_RST;
      bit_cnt_ff    <= '0;
      in_frame_ff   <= 1'b0;
      frame_done_ff <= 1'b0;
      frame_word_ff <= SHIFT_RST;
    end
    else
    begin
      frame_done_ff <= 1'b0;
      if (lnk.frame_n)
      begin
        in_frame_ff <= 1'b0;
        bit_cnt_ff  <= '0;
      end
      else if (frame_go && bit_cnt_ff == '0)
        in_frame_ff <= 1'b1;
      if (capture)
      begin
        shift_ff   <= {shift_ff[22:0], lnk.data};
        bit_cnt_ff <= bit_cnt_ff + CNT_W'(1);
      end
      if (last_bit)
      begin
        in_frame_ff   <= 1'b0;
        frame_done_ff <= 1'b1;
        frame_word_ff <= {shift_ff[22:0], lnk.data};
      end
    end
  end

  // RULE_11 serial output on rising edges
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sdo_ff <= 1'b0;
    else if (lnk.sclk_rise && !lnk.frame_n)
      sdo_ff <= shift_ff[23];
  end
  assign serial_out = sdo_ff;

  // RULE_06 reset loads both registers
  // RULE_08 power-up level
  // RULE_12 reset codes
  // RULE_10 simultaneous update
  // RULE_05 load ignored in reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      input_a_ff <= DW'(CODE_ZERO);
      input_b_ff <= DW'(CODE_ZERO);
      dac_a_ff   <= DW'(CODE_ZERO);
      dac_b_ff   <= DW'(CODE_ZERO);
    end
    else if (state_ff != DSR_ST_RUN || rst_fall)
    begin
      input_a_ff <= reset_code(sel_mid);
      input_b_ff <= reset_code(sel_mid);
      dac_a_ff   <= reset_code(sel_mid);
      dac_b_ff   <= reset_code(sel_mid);
    end
    else if (load_outputs_n_fall)
    begin
      dac_a_ff <= input_a_ff;
      dac_b_ff <= input_b_ff;
    end
  end

  // RULE_09 reference pin direction
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ref_out_en_ff <= 1'b1;
    else
      ref_out_en_ff <= ~ext_ref_select;
  end

  // Assertions.
  // RULE_05 check
  // While reset is low both outputs show only the reset code, whatever the load pin does.
  load_blocked_a: assert property (@(posedge clock) disable iff (rst) // RULE_05
    !rstn_lvl |=> dac_a_ff == reset_code($past(sel_mid))
      && dac_b_ff == reset_code($past(sel_mid)))
    else $error("load acted during reset");
  // RULE_01 check
  frame_len_a: assert property (@(posedge clock) disable iff (rst) // RULE_01
    frame_done_ff |-> $past(bit_cnt_ff) == FRAME_LAST)
    else $error("frame not 24 bits");
  // RULE_02 check
  shift_in_a: assert property (@(posedge clock) disable iff (rst) // RULE_02
    capture |=> shift_ff[0] == $past(lnk.data))
    else $error("shift missed data");
  // RULE_06 check
  reset_load_a: assert property (@(posedge clock) disable iff (rst) // RULE_06
    rst_fall |=> input_b_ff == reset_code($past(sel_mid)) && dac_b_ff == input_b_ff)
    else $error("reset load wrong");
  // RULE_07 check
  hold_reset_a: assert property (@(posedge clock) disable iff (rst) // RULE_07
    !rstn_lvl |=> !ready_ff)
    else $error("init not deferred");
  // RULE_10 check
  load_copy_a: assert property (@(posedge clock) disable iff (rst) // RULE_10
    load_outputs_n_fall && !rst_fall |=> dac_a_ff == $past(input_a_ff) && dac_b_ff == $past(input_b_ff))
    else $error("load copy wrong");
  // RULE_11 check
  sdo_rise_a: assert property (@(posedge clock) disable iff (rst) // RULE_11
    !lnk.sclk_rise |=> $stable(sdo_ff))
    else $error("serial out moved off rising edge");
  // RULE_12 check
  mid_code_a: assert property (@(posedge clock) disable iff (rst) // RULE_12
    (state_ff == DSR_ST_HOLD && sel_mid) |=> dac_a_ff[DW-1] && dac_a_ff[DW-2:0] == '0)
    else $error("midscale code wrong");
  // RULE_09 check
  ref_dir_a: assert property (@(posedge clock) disable iff (rst) // RULE_09
    !ext_ref_select [*2] |-> ref_out_en_ff)
    else $error("reference pin not output");
  frame_cov: cover property (@(posedge clock) disable iff (rst) frame_done_ff);
  load_cov: cover property (@(posedge clock) disable iff (rst) load_outputs_n_fall);
  reset_cov: cover property (@(posedge clock) disable iff (rst) rst_fall && sel_mid);
endmodule

// ==== test/dsr_host.sv ====
// Host master model that drives frames onto the serial link pins.
// Assumes one caller at a time; the link clock idles high between frames.
`timescale 1ns/1ps
module dsr_host (
  output logic        sclk,
  output logic        frame_n,
  output logic        serial_in,
  input  logic        serial_out,
  output logic [23:0] shifted_out
);
  // Pins start idle so the block sees no frame before the first call.
  initial
  begin
    sclk = 1'b1;
    frame_n = 1'b1;
    serial_in = 1'b0;
    shifted_out = 24'h000000;
  end
  // falling edges at 200 ns
  // Sends the top n bits of w, most significant first, then closes the frame.
  // What the block shifts out is collected on the same falling edges, as a chained part would.
  task automatic send(input logic [23:0] w, input int n);
    frame_n = 1'b0;
    shifted_out = 24'h000000;
    for (int i = 23; i > 23 - n; i--)
    begin
      serial_in = w[i];
      #100 sclk = 1'b0;
      shifted_out = {shifted_out[22:0], serial_out};
      #100 sclk = 1'b1;
    end
    #100 frame_n = 1'b1;
    // Released data shows the inverse of the last bit, so a stale value never looks valid.
    serial_in = ~serial_in;
    #200;
  endtask
endmodule

// ==== test/dual_dac_serial_input_reset_test.sv ====
// Self-checking bench for the serial front end and reset logic.
// Assumes the host model drives the link pins and the bench drives the rest.
`timescale 1ns/1ps
module dual_dac_serial_input_reset_test;
  import dsr_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        reset_n = 1'b1;
  logic        load_outputs_n = 1'b1;
  logic        reset_level_select = 1'b1;
  logic        ext_ref_select = 1'b0;
  logic        sclk, frame_n, serial_in, serial_out, frame_done_ff, ref_out_en_ff, ready_ff;
  logic [15:0] dac_a_ff, dac_b_ff, input_a_ff, input_b_ff;
  logic [23:0] frame_word_ff;
  logic [23:0] shifted_out;
  int          bad_count = 0;
  int          tests_run = 0;
  int          dones = 0;
  // Half of the 25 ns period.
  always #12.5 clock = ~clock;
  dsr_host host (.sclk(sclk), .frame_n(frame_n), .serial_in(serial_in),
    .serial_out(serial_out), .shifted_out(shifted_out));
  dsr_core dut (.clock(clock), .rst(rst), .sclk(sclk), .frame_n(frame_n),
    .serial_in(serial_in), .reset_n(reset_n), .load_outputs_n(load_outputs_n),
    .reset_level_select(reset_level_select), .ext_ref_select(ext_ref_select),
    .serial_out(serial_out), .dac_a_ff(dac_a_ff), .dac_b_ff(dac_b_ff),
    .input_a_ff(input_a_ff), .input_b_ff(input_b_ff), .frame_word_ff(frame_word_ff),
    .frame_done_ff(frame_done_ff), .ref_out_en_ff(ref_out_en_ff), .ready_ff(ready_ff));
  // Completion pulses are counted so that lost or extra frames show up.
  always @(negedge clock)
    if (frame_done_ff === 1'b1)
      dones++;
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait, so a block that never comes up fails instead of hanging.
  task automatic wait_ready();
    for (int i = 0; i < 40 && ready_ff !== 1'b1; i++)
      @(posedge clock);
    @(negedge clock);
  endtask
  task automatic codes(input logic [15:0] c);
    chk({8'h00, dac_a_ff}, {8'h00, c});
    chk({8'h00, dac_b_ff}, {8'h00, c});
    chk({8'h00, input_a_ff}, {8'h00, c});
    chk({8'h00, input_b_ff}, {8'h00, c});
  endtask
  // Main sequence: power-up, frames, reset pin, deferred power-up.
  initial
  begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    wait_ready();
    chk(24'(ready_ff), 24'h000001);
    codes(CODE_MID);
    chk(24'(ref_out_en_ff), 24'h000001);
    ext_ref_select = 1'b1;
    repeat (4) @(negedge clock);
    chk(24'(ref_out_en_ff), 24'h000000);
    host.send(24'hA5C30F, 24);
    repeat (8) @(negedge clock);
    chk(frame_word_ff, 24'hA5C30F);
    // After a full frame the output pin holds the top bit of the word just taken in.
    chk(24'(serial_out), 24'h000001);
    // An aborted frame must leave no trace in the word captured by the next one.
    host.send(24'hFFFFFF, 10);
    host.send(24'h5A3CF1, 24);
    repeat (8) @(negedge clock);
    chk(frame_word_ff, 24'h5A3CF1);
    // Readback during that frame is the old contents left by the cut frame.
    chk(shifted_out, 24'h0C3FFF);
    chk(24'(dones), 24'h000002);
    reset_level_select = 1'b0;
    reset_n = 1'b0;
    repeat (6) @(negedge clock);
    codes(CODE_ZERO);
    chk(24'(ready_ff), 24'h000000);
    load_outputs_n = 1'b0;
    repeat (4) @(negedge clock);
    load_outputs_n = 1'b1;
    repeat (4) @(negedge clock);
    codes(CODE_ZERO);
    reset_n = 1'b1;
    wait_ready();
    load_outputs_n = 1'b0;
    repeat (4) @(negedge clock);
    load_outputs_n = 1'b1;
    repeat (4) @(negedge clock);
    codes(CODE_ZERO);
    // Reset pin low across power-up must keep the block waiting.
    rst = 1'b1;
    reset_n = 1'b0;
    reset_level_select = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (30) @(negedge clock);
    chk(24'(ready_ff), 24'h000000);
    reset_n = 1'b1;
    wait_ready();
    chk(24'(ready_ff), 24'h000001);
    codes(CODE_MID);
    close_out();
  end
  // Watchdog well beyond the roughly 15 us that the sequence needs.
  initial
  begin
    #400000;
    bad_count++;
    close_out();
  end
endmodule
